/* design/ptr_sequencer.sv */
// point table repeat and pause sequencer for automatic operation
// Summary of operation
// - lowest digit of command method equal to one selects absolute method.
// - absolute, code 8 ends sequence there, then restarts from start table.
// - absolute, code 9 ends sequence there, then restarts from table one.
// - incremental, code 8 on last table loops to start table forever.
// - incremental varying speed, code 10 changes speed onward to table one.
// - varying speed steps to next table without stopping, zero dwell.
// - table number outputs keep their last value during automatic continuous runs.
// - pause decelerates with current table deceleration, then holds stopped.
// - pause again while held resumes the stored remaining travel.
// - start inputs are ignored while held in temporary stop.
// - while held, manual mode, servo off or clear wipe remaining travel.
// - pause input ignored during home return and manual jog.
// - pause acts only in accel or constant speed; restart only from hold.
// - only four discrete outputs exist, so five table bits never all show.
`timescale 1ns/1ps
module ptr_sequencer
  import ptr_pkg::*;
#(
  parameter int unsigned MS_CNT = MS_CYCLES
) (
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                auto_mode_select,
  input  wire logic                forward_start_input,
  input  wire logic                reverse_start_input,
  input  wire logic                pause_resume_input,
  input  wire logic                clear_input,
  input  wire logic                servo_on_input,
  input  wire logic [TBL_W-1:0]    table_select_input,
  input  wire logic [3:0]          command_method_param,
  input  wire logic                home_return_active,
  input  wire logic [AUX_W-1:0]    table_aux,
  input  wire logic [DWELL_W-1:0]  table_dwell_ms,
  input  wire logic [1:0]          motion_phase,
  input  wire logic                motion_done,
  output logic [TBL_W-1:0]         table_index,
  output ptr_move_t                move_req,
  output logic                     decel_req,
  output logic                     resume_req,
  output logic                     clear_remaining,
  output logic                     paused,
  output logic [DO_COUNT-1:0]      table_number_outputs,
  output logic                     table_number_valid
);
  ptr_regs_t r_ff;
  ptr_regs_t nxt_r;
  ptr_pins_t pins;
  logic      abs_mode;
  logic      pause_edge;
  logic      start_edge;
  logic      pause_ok;
  logic      loop_tbl;
  logic      vary_next;
  logic      stop_here;
  logic [TBL_W-1:0] next_tbl;

  always_comb begin
    pins.auto_mode = auto_mode_select;
    pins.fwd       = forward_start_input;
    pins.rev       = reverse_start_input;
    pins.pause     = pause_resume_input;
    pins.clr       = clear_input;
    pins.servo_on  = servo_on_input;
    pins.tsel      = table_select_input;
  end

  assign abs_mode   = (command_method_param == METHOD_ABS);
  assign pause_edge = r_ff.sync2.pause & ~r_ff.pause_prev;
  assign start_edge = (r_ff.sync2.fwd | r_ff.sync2.rev) & ~r_ff.start_prev;
  // pause only counts in automatic mode and outside home return
  assign pause_ok   = pause_edge & r_ff.sync2.auto_mode & ~home_return_active;

  // successor decode for the table that just completed
  always_comb begin
    next_tbl  = r_ff.cur + 5'h01;
    vary_next = 1'b0;
    stop_here = 1'b0;
    loop_tbl  = 1'b0;
    unique case (table_aux)
      AUX_CONT: next_tbl = r_ff.cur + 5'h01;
      AUX_VARY: vary_next = 1'b1;
      AUX_LOOP_START: begin
        next_tbl = r_ff.start_tbl;
        loop_tbl = 1'b1;
      end
      AUX_LOOP_ONE: begin
        next_tbl = TABLE_ONE;
        loop_tbl = 1'b1;
      end
      AUX_VARY_ONE: begin
        next_tbl  = TABLE_ONE;
        vary_next = 1'b1;
        stop_here = abs_mode;
      end
      AUX_INC_ONE: begin
        next_tbl  = TABLE_ONE;
        loop_tbl  = 1'b1;
        stop_here = abs_mode;
      end
      default: stop_here = 1'b1;
    endcase
  end

  always_comb begin
    nxt_r            = r_ff;
    nxt_r.sync1      = pins;
    nxt_r.sync2      = r_ff.sync1;
    nxt_r.pause_prev = r_ff.sync2.pause;
    nxt_r.start_prev = r_ff.sync2.fwd | r_ff.sync2.rev;
    nxt_r.move.start = 1'b0;
    nxt_r.decel_req  = 1'b0;
    nxt_r.resume_req = 1'b0;
    nxt_r.clear_rem  = 1'b0;
    // millisecond enable for dwell timing
    nxt_r.ms_tick    = 1'b0;
    if (r_ff.ms_cnt == 18'(MS_CNT - 1)) begin
      nxt_r.ms_cnt  = '0;
      nxt_r.ms_tick = 1'b1;
    end else begin
      nxt_r.ms_cnt = r_ff.ms_cnt + 18'h00001;
    end
    unique case (r_ff.state)
      PTR_IDLE: begin
        if (start_edge && r_ff.sync2.auto_mode && r_ff.sync2.servo_on) begin
          nxt_r.cur           = r_ff.sync2.tsel;
          nxt_r.start_tbl     = r_ff.sync2.tsel;
          nxt_r.reverse       = r_ff.sync2.rev & ~r_ff.sync2.fwd;
          nxt_r.move.start    = 1'b1;
          nxt_r.move.vary     = 1'b0;
          nxt_r.move.reverse  = r_ff.sync2.rev & ~r_ff.sync2.fwd;
          nxt_r.move.table_no = r_ff.sync2.tsel;
          nxt_r.tbl_valid     = 1'b0;
          nxt_r.cont_run      = 1'b0;
          nxt_r.state         = PTR_RUN;
        end
      end
      PTR_RUN: begin
        if (pause_ok && (motion_phase == PH_ACCEL ||
                         motion_phase == PH_CONST)) begin
          nxt_r.decel_req = 1'b1;
          nxt_r.state     = PTR_PAUSING;
        end else if (motion_done) begin
          if (stop_here) begin
            nxt_r.state     = PTR_IDLE;
            // only a lone table reports its number
            nxt_r.tbl_valid = ~r_ff.cont_run;
            // continuous runs leave the number outputs alone
            if (!r_ff.cont_run) begin
              nxt_r.tbl_out = r_ff.cur[DO_COUNT-1:0];
            end
          end else if (vary_next) begin
            nxt_r.cur           = next_tbl;
            nxt_r.cont_run      = 1'b1;
            nxt_r.move.start    = 1'b1;
            nxt_r.move.vary     = 1'b1;
            nxt_r.move.table_no = next_tbl;
          end else begin
            nxt_r.cur        = next_tbl;
            nxt_r.cont_run   = 1'b1;
            nxt_r.dwell_left = table_dwell_ms;
            nxt_r.state      = PTR_DWELL;
          end
        end
      end
      PTR_DWELL: begin
        // the loop back restarts like a fresh start
        if (r_ff.dwell_left == '0) begin
          nxt_r.move.start    = 1'b1;
          nxt_r.move.vary     = 1'b0;
          nxt_r.move.table_no = r_ff.cur;
          nxt_r.state         = PTR_RUN;
        end else if (r_ff.ms_tick) begin
          nxt_r.dwell_left = r_ff.dwell_left - 16'h0001;
        end
      end
      PTR_PAUSING: begin
        if (motion_phase == PH_STOP) begin
          nxt_r.state = PTR_HOLD;
        end
      end
      PTR_HOLD: begin
        // start inputs have no branch here, so they are ignored
        if (!r_ff.sync2.auto_mode || !r_ff.sync2.servo_on ||
            r_ff.sync2.clr) begin
          nxt_r.clear_rem = 1'b1;
          nxt_r.cont_run  = 1'b0;
          nxt_r.state     = PTR_IDLE;
        end else if (pause_ok) begin
          nxt_r.resume_req = 1'b1;
          nxt_r.state      = PTR_RUN;
        end
      end
    endcase
    // leaving auto mode mid-move abandons the pattern
    if (r_ff.state != PTR_HOLD && r_ff.state != PTR_IDLE &&
        !r_ff.sync2.auto_mode) begin
      nxt_r.state    = PTR_IDLE;
      nxt_r.cont_run = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r_ff <= '{state: PTR_IDLE, default: '0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign table_index          = r_ff.cur;
  assign move_req             = r_ff.move;
  assign decel_req            = r_ff.decel_req;
  assign resume_req           = r_ff.resume_req;
  assign clear_remaining      = r_ff.clear_rem;
  assign paused               = (r_ff.state == PTR_HOLD);
  assign table_number_outputs = r_ff.tbl_out;
  assign table_number_valid   = r_ff.tbl_valid;

  // checks
  default clocking chk_cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_cont_no_out: assert property (
    r_ff.cont_run |-> !table_number_valid)
    else $error("table number shown during continuous run");
  chk_pause_decel: assert property (
    (r_ff.state == PTR_RUN && pause_ok && motion_phase == PH_CONST)
    |=> decel_req && r_ff.state == PTR_PAUSING)
    else $error("pause did not request deceleration");
  chk_pause_hold: assert property (
    (r_ff.state == PTR_PAUSING && motion_phase == PH_STOP &&
     r_ff.sync2.auto_mode) |=> paused)
    else $error("stopped pause did not enter temporary stop");
  chk_resume_hold: assert property (
    resume_req |-> $past(r_ff.state) == PTR_HOLD)
    else $error("resume not from temporary stop");
  chk_hold_nostart: assert property (
    r_ff.state == PTR_HOLD |=> !move_req.start)
    else $error("start taken during temporary stop");
  chk_hold_clear: assert property (
    (r_ff.state == PTR_HOLD && r_ff.sync2.clr)
    |=> clear_remaining && r_ff.state == PTR_IDLE)
    else $error("remaining distance not cleared");
  chk_hold_servo: assert property (
    (r_ff.state == PTR_HOLD && !r_ff.sync2.servo_on)
    |=> clear_remaining && r_ff.state == PTR_IDLE)
    else $error("servo off did not clear remaining distance");
  chk_hold_manual: assert property (
    (r_ff.state == PTR_HOLD && !r_ff.sync2.auto_mode)
    |=> clear_remaining && r_ff.state == PTR_IDLE)
    else $error("manual mode did not clear remaining distance");
  chk_hold_resume: assert property (
    (r_ff.state == PTR_HOLD && pause_ok && r_ff.sync2.servo_on &&
     !r_ff.sync2.clr) |=> resume_req && r_ff.state == PTR_RUN)
    else $error("pause in temporary stop did not resume");
  chk_home_ignore: assert property (
    (home_return_active && r_ff.state == PTR_RUN) |=> !decel_req)
    else $error("pause acted during home return");
  chk_manual_ignore: assert property (
    !r_ff.sync2.auto_mode |=> !decel_req && !resume_req)
    else $error("pause acted in manual mode");
  chk_decel_ignore: assert property (
    (r_ff.state == PTR_RUN && motion_phase == PH_DECEL) |=> !decel_req)
    else $error("pause acted while decelerating");
  chk_vary_nostop: assert property (
    (r_ff.state == PTR_RUN && motion_done && table_aux == AUX_VARY &&
     r_ff.sync2.auto_mode)
    |=> move_req.start && move_req.vary && r_ff.state == PTR_RUN)
    else $error("varying speed step stopped");
  chk_inc_vary_one: assert property (
    (r_ff.state == PTR_RUN && motion_done && table_aux == AUX_VARY_ONE &&
     command_method_param != METHOD_ABS && r_ff.sync2.auto_mode)
    |=> move_req.start && move_req.vary && move_req.table_no == TABLE_ONE)
    else $error("code 10 did not change speed onward to table one");
  chk_loop_start: assert property (
    (r_ff.state == PTR_RUN && motion_done && table_aux == AUX_LOOP_START)
    |=> r_ff.cur == $past(r_ff.start_tbl))
    else $error("code 8 did not loop to start table");
  chk_loop_one: assert property (
    (r_ff.state == PTR_RUN && motion_done && table_aux == AUX_LOOP_ONE)
    |=> r_ff.cur == TABLE_ONE)
    else $error("code 9 did not loop to table one");
  chk_dwell_fresh: assert property (
    (r_ff.state == PTR_DWELL && r_ff.dwell_left == '0 &&
     r_ff.sync2.auto_mode) |=> move_req.start && !move_req.vary)
    else $error("loop back not restarted as fresh start");
  chk_stop_shows: assert property (
    (r_ff.state == PTR_RUN && motion_done && table_aux == AUX_STOP &&
     !r_ff.cont_run && !pause_ok && r_ff.sync2.auto_mode)
    |=> table_number_valid &&
        table_number_outputs == $past(r_ff.cur[DO_COUNT-1:0]))
    else $error("lone table number not shown");

  cov_loop: cover property (@(posedge mclk) disable iff (rst)
    r_ff.state == PTR_DWELL ##1 r_ff.state == PTR_RUN);
  cov_hold: cover property (@(posedge mclk) disable iff (rst)
    r_ff.state == PTR_HOLD ##1 resume_req);
  cov_clear: cover property (@(posedge mclk) disable iff (rst)
    clear_remaining);
  cov_vary: cover property (@(posedge mclk) disable iff (rst)
    move_req.start && move_req.vary);
  cov_stop_out: cover property (@(posedge mclk) disable iff (rst)
    table_number_valid);
endmodule

/* design/ptr_pkg.sv */
// package: types and constants for the point table repeat sequencer
package ptr_pkg;
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned MS_PS         = 1000000000;
  localparam int unsigned MS_CYCLES     = MS_PS / CLK_PERIOD_PS;
  localparam int unsigned TBL_W         = 5;
  localparam int unsigned AUX_W         = 4;
  localparam int unsigned DWELL_W       = 16;
  localparam int unsigned DO_COUNT      = 4;
  localparam logic [3:0] METHOD_ABS     = 4'h1;
  localparam logic [3:0] AUX_STOP       = 4'h0;
  localparam logic [3:0] AUX_CONT       = 4'h1;
  localparam logic [3:0] AUX_VARY       = 4'h3;
  localparam logic [3:0] AUX_LOOP_START = 4'h8;
  localparam logic [3:0] AUX_LOOP_ONE   = 4'h9;
  localparam logic [3:0] AUX_VARY_ONE   = 4'ha;
  localparam logic [3:0] AUX_INC_ONE    = 4'hb;
  localparam logic [4:0] TABLE_ONE      = 5'h01;
  localparam logic [1:0] PH_STOP        = 2'h0;
  localparam logic [1:0] PH_ACCEL       = 2'h1;
  localparam logic [1:0] PH_CONST       = 2'h2;
  localparam logic [1:0] PH_DECEL       = 2'h3;

  typedef enum logic [2:0] {
    PTR_IDLE, PTR_RUN, PTR_DWELL, PTR_PAUSING, PTR_HOLD
  } ptr_state_t;

  // pins that arrive from the host and must be synchronised
  typedef struct packed {
    logic             auto_mode;
    logic             fwd;
    logic             rev;
    logic             pause;
    logic             clr;
    logic             servo_on;
    logic [TBL_W-1:0] tsel;
  } ptr_pins_t;

  // request toward the profile generator
  typedef struct packed {
    logic             start;
    logic             vary;
    logic             reverse;
    logic [TBL_W-1:0] table_no;
  } ptr_move_t;

  typedef struct packed {
    ptr_state_t       state;
    ptr_pins_t        sync1;
    ptr_pins_t        sync2;
    logic             pause_prev;
    logic             start_prev;
    logic [TBL_W-1:0] cur;
    logic [TBL_W-1:0] start_tbl;
    logic             reverse;
    logic [DWELL_W-1:0] dwell_left;
    logic [17:0]      ms_cnt;
    logic             ms_tick;
    ptr_move_t        move;
    logic             decel_req;
    logic             resume_req;
    logic             clear_rem;
    logic             cont_run;
    logic             tbl_valid;
    logic [DO_COUNT-1:0] tbl_out;
  } ptr_regs_t;
endpackage

/* dv/ptr_host_model.sv */
// host side model: table memory and a stand-in motion profile
`timescale 1ns/1ps
module ptr_host_model
  import ptr_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire ptr_move_t            move_req,
  input  wire logic                 decel_req,
  input  wire logic                 resume_req,
  input  wire logic [TBL_W-1:0]     table_index,
  output logic [AUX_W-1:0]          table_aux,
  output logic [DWELL_W-1:0]        table_dwell_ms,
  output logic [1:0]                motion_phase,
  output logic                      motion_done
);
  logic [AUX_W-1:0] aux_mem [32];
  logic [5:0]       cnt_ff;
  logic             halt_ff;
  assign table_aux      = aux_mem[table_index];
  assign table_dwell_ms = 16'h0002;
  // a halted move only decelerates and never reports done
  assign motion_phase = (cnt_ff == 6'h00) ? PH_STOP :
                        (halt_ff || cnt_ff < 6'h07) ? PH_DECEL :
                        (cnt_ff > 6'h18) ? PH_ACCEL : PH_CONST;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_ff      <= 6'h00;
      halt_ff     <= 1'b0;
      motion_done <= 1'b0;
    end else begin
      motion_done <= 1'b0;
      if (move_req.start || resume_req) begin
        cnt_ff  <= 6'h1e;
        halt_ff <= 1'b0;
      end else if (decel_req) begin
        cnt_ff  <= 6'h06;
        halt_ff <= 1'b1;
      end else if (cnt_ff != 6'h00) begin
        cnt_ff      <= cnt_ff - 6'h01;
        motion_done <= (cnt_ff == 6'h01) && !halt_ff;
      end
    end
  end
endmodule

/* dv/ptr_sequencer_tb.sv */
// self-checking bench for the point table repeat sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) checks_done++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
  end
module ptr_sequencer_tb
  import ptr_pkg::*;
;
  typedef struct packed {
    logic [3:0] m;
    logic [3:0] a;
    logic       go;
    logic [4:0] t;
    logic       v;
  } ptr_row_t;
  localparam logic [4:0] T0 = 5'h12;
  // method, aux code, loops on, next table, speed change
  localparam ptr_row_t ROWS [10] = '{
    '{4'h1, 4'h1, 1'b1, 5'h13, 1'b0}, '{4'h1, 4'h3, 1'b1, 5'h13, 1'b1},
    '{4'h1, 4'h8, 1'b1, T0, 1'b0}, '{4'h1, 4'h9, 1'b1, 5'h01, 1'b0},
    '{4'h1, 4'ha, 1'b0, T0, 1'b0}, '{4'h0, 4'h8, 1'b1, T0, 1'b0},
    '{4'h0, 4'h9, 1'b1, 5'h01, 1'b0}, '{4'h0, 4'ha, 1'b1, 5'h01, 1'b1},
    '{4'h0, 4'hb, 1'b1, 5'h01, 1'b0}, '{4'h0, 4'h0, 1'b0, T0, 1'b0}};
  logic mclk, rst, auto_m, fwd, rev, pause, clr, servo, home, decel, resume;
  logic clr_rem, paused, valid, done;
  logic [4:0] tsel, tidx;
  logic [3:0] meth, aux, tno;
  logic [15:0] dwell;
  logic [1:0] phase;
  ptr_move_t mv, last_mv;
  int mismatches, checks_done, cyc;
  int ev [4];
  int bs [4];
  ptr_sequencer #(.MS_CNT(4)) i_dut (.mclk(mclk), .rst(rst),
    .auto_mode_select(auto_m), .forward_start_input(fwd),
    .reverse_start_input(rev), .pause_resume_input(pause),
    .clear_input(clr), .servo_on_input(servo), .table_select_input(tsel),
    .command_method_param(meth), .home_return_active(home),
    .table_aux(aux), .table_dwell_ms(dwell), .motion_phase(phase),
    .motion_done(done), .table_index(tidx), .move_req(mv),
    .decel_req(decel), .resume_req(resume), .clear_remaining(clr_rem),
    .paused(paused), .table_number_outputs(tno),
    .table_number_valid(valid));
  ptr_host_model i_host (.mclk(mclk), .rst(rst), .move_req(mv),
    .decel_req(decel), .resume_req(resume), .table_index(tidx),
    .table_aux(aux), .table_dwell_ms(dwell), .motion_phase(phase),
    .motion_done(done));
  // pulses are counted so a task never misses one that lands mid-pulse
  always @(posedge mclk) begin
    cyc++;
    if (mv.start === 1'b1) begin
      ev[0]++;
      last_mv = mv;
    end
    if (decel === 1'b1) ev[1]++;
    if (resume === 1'b1) ev[2]++;
    if (clr_rem === 1'b1) ev[3]++;
    if (cyc == 5000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic drive(input int k, input logic v);
    @(posedge mclk);
    case (k)
      0: fwd <= v;
      1: pause <= v;
      2: rev <= v;
      3: auto_m <= v;
      4: servo <= v;
      5: clr <= v;
      default: home <= v;
    endcase
  endtask
  // pins stay stable well over the two-cycle synchroniser need
  task automatic pulse(input int k);
    bs = ev;
    drive(k, 1'b1);
    repeat (2) @(posedge mclk);
    drive(k, 1'b0);
    repeat (2) @(posedge mclk);
  endtask
  task automatic wait_ev(input int k, input int n, output logic got);
    repeat (n) begin
      @(negedge mclk);
      if (ev[k] != bs[k]) break;
    end
    got = (ev[k] != bs[k]);
  endtask
  task automatic go_const();
    pulse(0);
    repeat (60) begin
      @(negedge mclk);
      if (phase === PH_CONST) break;
    end
  endtask
  task automatic run_row(input ptr_row_t r);
    logic got;
    i_host.aux_mem[T0] <= r.a;
    @(posedge mclk);
    meth <= r.m;
    drive(3, 1'b1);
    pulse(0);
    wait_ev(0, 20, got);
    `CHK("first start", 1'b1, got)
    `CHK("first table", T0, last_mv.table_no)
    bs = ev;
    wait_ev(0, 80, got);
    `CHK("loop start", r.go, got)
    `CHK("table index", r.t, tidx)
    if (r.go) begin
      `CHK("next table", r.t, last_mv.table_no)
      `CHK("speed change", r.v, last_mv.vary)
      `CHK("no table out", 1'b0, valid)
    end else begin
      `CHK("table out", 4'h2, tno)
      `CHK("table valid", 1'b1, valid)
    end
    drive(3, 1'b0);
    repeat (40) @(posedge mclk);
  endtask
  task automatic hold_run();
    logic got;
    go_const();
    pulse(1);
    wait_ev(1, 10, got);
    `CHK("decel", 1'b1, got)
    repeat (20) begin
      @(negedge mclk);
      if (paused === 1'b1) break;
    end
    `CHK("paused", 1'b1, paused)
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    logic got;
    {auto_m, fwd, rev, pause, clr, home} = 6'h00;
    servo = 1'b1;
    tsel = T0;
    meth = 4'h1;
    rst = 1'b1;
    foreach (i_host.aux_mem[i]) i_host.aux_mem[i] = 4'h0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK("reset move", 8'h00, mv)
    `CHK("reset paused", 1'b0, paused)
    foreach (ROWS[i]) run_row(ROWS[i]);
    drive(3, 1'b1);
    for (int k = 0; k < 4; k++) begin
      hold_run();
      if (k == 0) begin
        pulse(2);
        wait_ev(0, 10, got);
        `CHK("start in hold", 1'b0, got)
        pulse(1);
        wait_ev(2, 10, got);
        `CHK("resume", 1'b1, got)
        repeat (60) @(posedge mclk);
      end else begin
        bs = ev;
        drive(k + 2, k == 3);
        wait_ev(3, 10, got);
        `CHK("clear", 1'b1, got)
        drive(k + 2, k != 3);
        repeat (10) @(posedge mclk);
      end
    end
    go_const();
    drive(6, 1'b1);
    pulse(1);
    wait_ev(1, 10, got);
    `CHK("pause in homing", 1'b0, got)
    drive(6, 1'b0);
    repeat (40) @(posedge mclk);
    // pause edge lands while the profile is already decelerating
    pulse(0);
    repeat (60) begin
      @(negedge mclk);
      if (phase === PH_DECEL) break;
    end
    pulse(1);
    wait_ev(1, 10, got);
    `CHK("pause in decel", 1'b0, got)
    repeat (20) @(posedge mclk);
    // reset in the middle of a move
    pulse(0);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    bs = ev;
    @(negedge mclk);
    `CHK("reset index", 5'h00, tidx)
    `CHK("reset valid", 1'b0, valid)
    `CHK("reset move mid", 8'h00, mv)
    wait_ev(0, 8, got);
    `CHK("start after reset", 1'b0, got)
    wrap_up();
  end
endmodule
